//--- rtl/ar_map.vh
// constants for the auto-reclose sequencer: register map, fields, timing
// assumes byte addresses on an 8-bit register port, one 32-bit word each
`ifndef AR_MAP_VH
`define AR_MAP_VH

// ********************************************************
// register offsets
// ********************************************************
`define AR_CTRL 8'h00
`define AR_STATUS 8'h04
`define AR_ARC_TIME 8'h08
`define AR_SEQ_RECLAIM 8'h0C
`define AR_REQ_CFG0 8'h10
`define AR_TBL_BASE 8'h40

// ********************************************************
// fields
// ********************************************************
`define AR_CTRL_ENABLE 0
`define AR_CTRL_SEQ_FINAL 1
`define AR_CTRL_RESET 2
`define AR_CFG_OWN_ARC_LSB 4
`define AR_CFG_INTERLOCK 8
`define AR_CFG_FINAL_REAPPEAR 9
`define AR_CFG_W 10
`define AR_TBL_DEAD_MSB 15
`define AR_TBL_RECLAIM_LSB 16
`define AR_CTRL_RESET_VAL 2'h1

// ********************************************************
// timing
// ********************************************************
`define AR_CLK_NS 20
`define AR_TICK_NS 1000000

`endif

//--- rtl/ar_settings_mem.v
// per-request, per-shot dead and reclaim time table
// one write port, two registered read ports; port b also returns
// an alternative word so the bus read data leave a single flop
module ar_settings_mem #(
  parameter DW = 32,
  parameter DEPTH = 20,
  parameter AW = 5
) (
  input wire clk_sys,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire [AW-1:0] a_addr,
  output reg [DW-1:0] a_data_q,
  input wire b_en,
  input wire b_tbl,
  input wire [AW-1:0] b_addr,
  input wire [DW-1:0] b_other,
  output reg [DW-1:0] b_data_q
);
  reg [DW-1:0] mem [0:DEPTH-1];

  // contents are undefined until software loads them
  always @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    a_data_q <= mem[a_addr];
    if (b_en) begin
      b_data_q <= b_tbl ? mem[b_addr] : b_other;
    end else begin
      b_data_q <= {DW{1'b0}};
    end
  end
endmodule // ar_settings_mem

//--- rtl/auto_reclose_sequencer.v
// auto-reclose sequencer: request arbitration, shot timers, breaker
// commands through the object-control function, final trip and lock-out
// assumes all inputs but arst_n synchronous to clk_sys; object answers are single-cycle pulses
`include "ar_map.vh"

// Notes on behaviour
// [R1] five reclose request inputs, each able to start a sequence
// [R2] request 0 ranks highest, request 4 lowest
// [R3] critical request stops reclosing at once, in any state
// [R4] after breaker opens, count dead time then command close
// [R5] persisting fault: next configured shot, or final trip with lock-out
// [R6] per shot: own arcing delay or protection's own operating time
// [R7] fault in reclaim window: arm next shot or final trip, per setting
// [R8] interlocking request aborts, issues final trip, latches lock-out
// [R9] lock-out refuses all reclosing until reset
// [R10] open/close only via object function; status from it too
// [R11] object wait state holds sequencer until close ack or failure
// [R12] any object failure acknowledgement forces lock-out
// [R13] lock-out clears on external reset or breaker closing
// [R14] request in shot reclaim advances to next shot indication
// [R15] no further shot: final trip, drop indications, lock-out
// [R16] timers set to zero are skipped
// [R17] simultaneous requests: serve highest, use its shot settings
// [R18] timers count whole ticks, restart at start of each state
module auto_reclose_sequencer #(
  parameter NREQ = 5,
  parameter SHOTS = 4,
  parameter SHOT_W = 2,
  parameter TW = 16,
  parameter TICK_CYCLES = `AR_TICK_NS / `AR_CLK_NS,
  parameter DIV_W = 16
) (
  input wire clk_sys,
  input wire arst_n,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output wire [31:0] rdata,
  input wire [NREQ-1:0] reclose_req,
  input wire critical_req,
  input wire ext_reset,
  input wire brk_closed,
  input wire obj_open_ack,
  input wire obj_open_fail,
  input wire obj_close_ack,
  input wire obj_close_fail,
  input wire obj_wait,
  output reg obj_open_cmd_q,
  output reg obj_close_cmd_q,
  output reg running_q,
  output reg [NREQ-1:0] requested_q,
  output reg [SHOTS-1:0] shot_running_q,
  output reg final_trip_q,
  output reg lockout_q
);
  localparam DEPTH = NREQ * SHOTS;
  localparam AW = 5;
  localparam [3:0] S_IDLE = 4'h0, S_LOAD = 4'h1, S_ARC = 4'h2,
    S_OPEN = 4'h3, S_WOPEN = 4'h4, S_DEAD = 4'h5, S_CLOSE = 4'h6,
    S_RECLAIM = 4'h7, S_SEQREC = 4'h8, S_FINAL = 4'h9, S_LOCK = 4'hA;

  // ********************************************************
  // functions
  // ********************************************************
  function [2:0] top_req;
    input [NREQ-1:0] r;
    integer i;
    begin
      top_req = 3'h0;
      for (i = NREQ - 1; i >= 0; i = i - 1) begin
        if (r[i]) top_req = i[2:0]; // R2 R17
      end
    end
  endfunction

  // first enabled shot above 'from'; bit SHOT_W flags a hit
  function [SHOT_W:0] find_shot;
    input [SHOTS-1:0] mask;
    input integer from;
    integer i;
    begin
      find_shot = {(SHOT_W+1){1'b0}};
      for (i = SHOTS - 1; i >= 0; i = i - 1) begin
        if (mask[i] && i > from) find_shot = {1'b1, i[SHOT_W-1:0]};
      end
    end
  endfunction

  // ********************************************************
  // registers
  // ********************************************************
  reg [1:0] ctrl_q;
  reg [TW-1:0] arc_time_q;
  reg [TW-1:0] seq_reclaim_q;
  reg [`AR_CFG_W-1:0] cfg_q [0:NREQ-1];
  reg sw_reset_q;
  reg [3:0] state_q, state_d;
  reg [2:0] req_q, req_d;
  reg [SHOT_W-1:0] shot_q, shot_d;
  reg [TW-1:0] tmr_q;
  reg [DIV_W-1:0] div_q;
  reg tick_q;
  reg brk_closed_q;
  reg [31:0] other_rd;
  reg [TW-1:0] limit;
  reg [SHOT_W:0] hit;
  wire [31:0] mem_a;
  wire [31:0] tbl_off = {24'h00_0000, addr} - {24'h00_0000, `AR_TBL_BASE};
  wire tbl_hit = (addr >= `AR_TBL_BASE) && (tbl_off[31:2] < DEPTH);
  wire [31:0] run_idx = req_q * SHOTS + shot_q;
  wire [2:0] new_req = top_req(reclose_req);
  wire [`AR_CFG_W-1:0] new_cfg = cfg_q[new_req];
  wire [`AR_CFG_W-1:0] cur_cfg = cfg_q[req_q];
  wire any_req = |reclose_req;
  wire [NREQ-1:0] lock_cfg;
  wire interlock = |(reclose_req & lock_cfg);
  wire tmr_done = (tmr_q >= limit);
  wire enabled = ctrl_q[`AR_CTRL_ENABLE];

  genvar g;
  generate
    for (g = 0; g < NREQ; g = g + 1) begin : g_lock
      assign lock_cfg[g] = cfg_q[g][`AR_CFG_INTERLOCK];
    end
  endgenerate

  // ********************************************************
  // register port
  // ********************************************************
  integer k;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= `AR_CTRL_RESET_VAL;
      arc_time_q <= 16'h0000;
      seq_reclaim_q <= 16'h0000;
      sw_reset_q <= 1'b0;
      for (k = 0; k < NREQ; k = k + 1) begin
        cfg_q[k] <= 10'h000;
      end
    end else begin
      sw_reset_q <= wr_stb && (addr == `AR_CTRL) &&
        wdata[`AR_CTRL_RESET];
      if (wr_stb) begin
        case (addr)
          `AR_CTRL: ctrl_q <= wdata[1:0];
          `AR_ARC_TIME: arc_time_q <= wdata[TW-1:0];
          `AR_SEQ_RECLAIM: seq_reclaim_q <= wdata[TW-1:0];
          default: begin
            for (k = 0; k < NREQ; k = k + 1) begin
              if (addr == `AR_REQ_CFG0 + k[7:0] * 8'h04)
                cfg_q[k] <= wdata[`AR_CFG_W-1:0];
            end
          end
        endcase
      end
    end
  end

  always @* begin
    other_rd = 32'h0000_0000;
    case (addr)
      `AR_CTRL: other_rd = {30'h0000_0000, ctrl_q};
      `AR_STATUS: other_rd = {18'h0_0000, obj_wait, lockout_q,
        1'b0, req_q, {(4-SHOT_W){1'b0}}, shot_q, state_q};
      `AR_ARC_TIME: other_rd = {16'h0000, arc_time_q};
      `AR_SEQ_RECLAIM: other_rd = {16'h0000, seq_reclaim_q};
      default: begin
        for (k = 0; k < NREQ; k = k + 1) begin
          if (addr == `AR_REQ_CFG0 + k[7:0] * 8'h04)
            other_rd = {22'h00_0000, cfg_q[k]};
        end
      end
    endcase
  end

  ar_settings_mem #(.DW(32), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .clk_sys(clk_sys),
    .wr_en(wr_stb && tbl_hit),
    .wr_addr(tbl_off[AW+1:2]),
    .wr_data(wdata),
    .a_addr(run_idx[AW-1:0]),
    .a_data_q(mem_a),
    .b_en(rd_stb),
    .b_tbl(tbl_hit),
    .b_addr(tbl_off[AW+1:2]),
    .b_other(other_rd),
    .b_data_q(rdata)
  );

  // ********************************************************
  // timebase and timers
  // ********************************************************
  always @* begin
    case (state_q)
      S_ARC: limit = arc_time_q;
      S_DEAD: limit = mem_a[`AR_TBL_DEAD_MSB:0];
      S_RECLAIM: limit = mem_a[`AR_TBL_RECLAIM_LSB+TW-1:`AR_TBL_RECLAIM_LSB];
      S_SEQREC: limit = seq_reclaim_q;
      default: limit = {TW{1'b0}};
    endcase
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 16'h0000;
      tick_q <= 1'b0;
      tmr_q <= 16'h0000;
      // closed idle level, so no false closing edge follows reset
      brk_closed_q <= 1'b1;
    end else begin
      brk_closed_q <= brk_closed;
      tick_q <= (div_q == TICK_CYCLES[DIV_W-1:0] - 16'h0001); // R18
      if (div_q == TICK_CYCLES[DIV_W-1:0] - 16'h0001) begin
        div_q <= 16'h0000;
      end else begin
        div_q <= div_q + 16'h0001;
      end
      // zero limit is done at once, so the state passes uncounted
      if (state_d != state_q) begin
        tmr_q <= 16'h0000; // R18
      end else if (tick_q && !tmr_done) begin
        tmr_q <= tmr_q + 16'h0001; // R16
      end
    end
  end

  // ********************************************************
  // sequence state machine
  // ********************************************************
  always @* begin
    state_d = state_q;
    req_d = req_q;
    shot_d = shot_q;
    hit = find_shot(new_cfg[SHOTS-1:0], -1);
    case (state_q)
      S_IDLE, S_SEQREC: begin
        if (state_q == S_SEQREC && tmr_done) state_d = S_IDLE; // R16
        if (enabled && any_req) begin // R1
          if (state_q == S_SEQREC && ctrl_q[`AR_CTRL_SEQ_FINAL]) begin
            state_d = S_FINAL;
          end else if (hit[SHOT_W]) begin
            req_d = new_req; // R17
            shot_d = hit[SHOT_W-1:0];
            state_d = S_LOAD;
          end
        end
      end
      S_LOAD: begin
        // own arcing delay, else protection trips the breaker itself
        if (cur_cfg[`AR_CFG_OWN_ARC_LSB + shot_q]) state_d = S_ARC; // R6
        else state_d = S_WOPEN;
      end
      S_ARC: if (tmr_done) state_d = S_OPEN; // R6
      S_OPEN: begin
        if (obj_open_fail) state_d = S_LOCK; // R12
        else if (obj_open_ack) state_d = S_DEAD; // R10
      end
      S_WOPEN: if (!brk_closed) state_d = S_DEAD; // R10
      S_DEAD: if (tmr_done) state_d = S_CLOSE; // R4
      S_CLOSE: begin
        // obj_wait only holds here until ack or failure
        if (obj_close_fail) state_d = S_LOCK; // R11 R12
        else if (obj_close_ack) state_d = S_RECLAIM; // R11
      end
      S_RECLAIM: begin
        hit = find_shot(cur_cfg[SHOTS-1:0], shot_q);
        if (any_req) begin
          if (cur_cfg[`AR_CFG_FINAL_REAPPEAR] || !hit[SHOT_W]) begin
            state_d = S_FINAL; // R7 R15
          end else begin
            shot_d = hit[SHOT_W-1:0]; // R5 R14
            state_d = S_LOAD;
          end
        end else if (tmr_done) begin
          state_d = S_SEQREC; // R16
        end
      end
      S_FINAL: begin
        if (obj_open_fail || obj_open_ack || !brk_closed)
          state_d = S_LOCK; // R5 R12
      end
      S_LOCK: begin
        if (ext_reset || sw_reset_q || (brk_closed && !brk_closed_q))
          state_d = S_IDLE; // R9 R13
      end
      default: state_d = S_IDLE;
    endcase
    if (interlock && state_q != S_LOCK && state_q != S_FINAL)
      state_d = S_FINAL; // R8
    if (critical_req) state_d = S_LOCK; // R3
    if (!enabled && state_q != S_LOCK && state_q != S_FINAL)
      state_d = S_IDLE;
  end

  // ********************************************************
  // state and registered outputs
  // ********************************************************
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= S_IDLE;
      req_q <= 3'h0;
      shot_q <= {SHOT_W{1'b0}};
      obj_open_cmd_q <= 1'b0;
      obj_close_cmd_q <= 1'b0;
      running_q <= 1'b0;
      requested_q <= {NREQ{1'b0}};
      shot_running_q <= {SHOTS{1'b0}};
      final_trip_q <= 1'b0;
      lockout_q <= 1'b0;
    end else begin
      state_q <= state_d;
      req_q <= req_d;
      shot_q <= shot_d;
      obj_open_cmd_q <= (state_d == S_OPEN) || (state_d == S_FINAL); // R10
      obj_close_cmd_q <= (state_d == S_CLOSE); // R10
      running_q <= (state_d >= S_LOAD) && (state_d <= S_RECLAIM); // R15
      requested_q <= {NREQ{1'b0}};
      shot_running_q <= {SHOTS{1'b0}};
      if ((state_d >= S_LOAD) && (state_d <= S_RECLAIM)) begin
        requested_q[req_d] <= 1'b1;
        shot_running_q[shot_d] <= 1'b1; // R14
      end
      final_trip_q <= (state_d == S_FINAL); // R5
      lockout_q <= (state_d == S_LOCK); // R9
    end
  end
endmodule // auto_reclose_sequencer

//--- tb/reclose_monitor.sv
// port checker for the auto-reclose sequencer
// assumes the block's clk_sys and active-low arst_n
module reclose_monitor #(
  parameter NREQ = 5,
  parameter SHOTS = 4
) (
  input wire clk_sys,
  input wire arst_n,
  input wire critical_req,
  input wire ext_reset,
  input wire wr_stb,
  input wire brk_closed,
  input wire obj_wait,
  input wire obj_close_ack,
  input wire obj_close_fail,
  input wire obj_open_fail,
  input wire obj_open_cmd_q,
  input wire obj_close_cmd_q,
  input wire running_q,
  input wire [NREQ-1:0] requested_q,
  input wire [SHOTS-1:0] shot_running_q,
  input wire final_trip_q,
  input wire lockout_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // sequences and properties
  // ****************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence close_done;
    obj_close_cmd_q && obj_close_ack;
  endsequence
  sequence close_held;
    obj_close_cmd_q && obj_wait && !obj_close_ack && !obj_close_fail
      && !critical_req;
  endsequence
  sequence obj_failed;
    (obj_close_cmd_q && obj_close_fail) || (obj_open_cmd_q && obj_open_fail);
  endsequence
  cmd_excl_a: assert property (
    !(obj_open_cmd_q && obj_close_cmd_q)) else $error("both commands");
  lock_noclose_a: assert property (
    lockout_q && !ext_reset && !brk_closed && !$past(wr_stb) |=> lockout_q)
    else $error("lock-out left without reset");
  crit_stop_a: assert property (
    critical_req |=> !running_q) else $error("critical did not stop");
  crit_lock_a: assert property (
    critical_req |-> ##[1:2] lockout_q) else $error("critical no lock");
  fail_lock_a: assert property (
    obj_failed |-> ##[1:2] lockout_q) else $error("failure no lock");
  close_drop_a: assert property (
    close_done |=> !obj_close_cmd_q) else $error("close not dropped");
  wait_hold_a: assert property (
    close_held |=> obj_close_cmd_q) else $error("close left in wait");
  start_ind_a: assert property (
    $rose(running_q) |-> $onehot(requested_q) && $onehot(shot_running_q))
    else $error("bad start indications");
  final_drop_a: assert property (
    $rose(final_trip_q) |-> !running_q && requested_q == '0)
    else $error("indications kept in final trip");
  ext_clear_a: assert property (
    lockout_q && ext_reset |-> ##[1:2] !lockout_q)
    else $error("lock-out not cleared");
endmodule // reclose_monitor

bind auto_reclose_sequencer reclose_monitor #(.NREQ(NREQ), .SHOTS(SHOTS))
  reclose_monitor_i (.clk_sys(clk_sys), .arst_n(arst_n),
  .critical_req(critical_req), .ext_reset(ext_reset), .obj_wait(obj_wait),
  .wr_stb(wr_stb), .brk_closed(brk_closed),
  .obj_close_ack(obj_close_ack), .obj_close_fail(obj_close_fail),
  .obj_open_fail(obj_open_fail), .obj_open_cmd_q(obj_open_cmd_q),
  .obj_close_cmd_q(obj_close_cmd_q), .running_q(running_q),
  .requested_q(requested_q), .shot_running_q(shot_running_q),
  .final_trip_q(final_trip_q), .lockout_q(lockout_q));

//--- tb/breaker_object_model.sv
// breaker object-control model: answers open and close commands
// assumes commands are levels held until an answer is seen
module breaker_object_model #(
  parameter DLY = 3,
  parameter WAIT_DLY = 12
) (
  input wire clk_sys,
  input wire arst_n,
  input wire open_cmd,
  input wire close_cmd,
  input wire trip,
  input wire fail_mode,
  input wire wait_mode,
  output reg brk_closed,
  output reg open_ack,
  output reg open_fail,
  output reg close_ack,
  output reg close_fail,
  output wire obj_wait
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // object behaviour
  // ****************************************
  reg done_q;
  reg [7:0] cnt_q;
  assign obj_wait = close_cmd & wait_mode & !done_q;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      brk_closed <= 1'b1;
      done_q <= 1'b0;
      cnt_q <= 8'h00;
      {open_ack, open_fail, close_ack, close_fail} <= 4'h0;
    end else begin
      // one answer per command, a single-cycle pulse
      {open_ack, open_fail, close_ack, close_fail} <= 4'h0;
      if (trip) begin
        brk_closed <= 1'b0;
      end
      if (!(open_cmd | close_cmd)) begin
        done_q <= 1'b0;
        cnt_q <= 8'h00;
      end else if (!done_q) begin
        cnt_q <= cnt_q + 8'h01;
        if (cnt_q == (wait_mode ? WAIT_DLY : DLY)) begin
          done_q <= 1'b1;
          if (fail_mode) begin
            open_fail <= open_cmd;
            close_fail <= close_cmd;
          end else if (close_cmd) begin
            brk_closed <= 1'b1;
            close_ack <= 1'b1;
          end else begin
            brk_closed <= 1'b0;
            open_ack <= 1'b1;
          end
        end
      end
    end
  end
endmodule // breaker_object_model

//--- tb/auto_reclose_sequencer_test.sv
// testbench: register port and reclose sequences with a breaker model
// assumes the block's map and a tick of 4 clocks
module auto_reclose_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, arst_n = 0, wr_stb = 0, rd_stb = 0, critical_req = 0;
  logic ext_reset = 0, trip = 0, fail_mode = 0, wait_mode = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [4:0] reclose_req = 5'h00;
  wire [31:0] rdata;
  wire [4:0] requested_q;
  wire [3:0] shot_running_q;
  wire brk_closed, open_ack, open_fail, close_ack, close_fail, obj_wait;
  wire obj_open_cmd_q, obj_close_cmd_q, running_q, final_trip_q, lockout_q;
  int err_count = 0, n_checks = 0;
  always #10 clk_sys = ~clk_sys;
  auto_reclose_sequencer #(.TICK_CYCLES(4)) auto_reclose_sequencer_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .reclose_req(reclose_req), .critical_req(critical_req),
    .ext_reset(ext_reset), .brk_closed(brk_closed), .obj_open_ack(open_ack),
    .obj_open_fail(open_fail), .obj_close_ack(close_ack),
    .obj_close_fail(close_fail), .obj_wait(obj_wait),
    .obj_open_cmd_q(obj_open_cmd_q), .obj_close_cmd_q(obj_close_cmd_q),
    .running_q(running_q), .requested_q(requested_q),
    .shot_running_q(shot_running_q), .final_trip_q(final_trip_q),
    .lockout_q(lockout_q));
  breaker_object_model breaker_object_model_i (.clk_sys(clk_sys),
    .arst_n(arst_n), .open_cmd(obj_open_cmd_q), .close_cmd(obj_close_cmd_q),
    .trip(trip), .fail_mode(fail_mode), .wait_mode(wait_mode),
    .brk_closed(brk_closed), .open_ack(open_ack), .open_fail(open_fail),
    .close_ack(close_ack), .close_fail(close_fail), .obj_wait(obj_wait));
  // ****************************************
  // tasks
  // ****************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    wr_stb <= 1; addr <= a; wdata <= d;
    @(posedge clk_sys); wr_stb <= 0;
    @(posedge clk_sys);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    rd_stb <= 1; addr <= a;
    @(posedge clk_sys); rd_stb <= 0;
    @(negedge clk_sys); chk(rdata, e);
    @(posedge clk_sys);
  endtask
  function logic sig(input int k);
    case (k)
      0: return lockout_q;
      1: return obj_open_cmd_q;
      2: return final_trip_q;
      3: return obj_close_cmd_q;
      default: return brk_closed;
    endcase
  endfunction
  // bounded wait, so a stuck output shows as a mismatch, not a hang
  task await(input int k, input logic v);
    int i;
    for (i = 0; i < 400 && sig(k) !== v; i++) @(posedge clk_sys);
    chk(sig(k), v);
  endtask
  task fire(input logic [4:0] r, input logic t);
    reclose_req <= r; trip <= t;
    @(posedge clk_sys); @(negedge clk_sys);
  endtask
  task drop;
    @(posedge clk_sys); await(4, 0);
    reclose_req <= 0; trip <= 0;
  endtask
  task reclose;
    await(3, 1); await(3, 0); await(4, 1);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ****************************************
  // sequence of tests
  // ****************************************
  initial begin
    #400000; err_count++; test_done;
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    arst_n <= 1;
    @(posedge clk_sys);
    rd(8'h00, 32'h0000_0001); rd(8'hFC, 32'h0000_0000);
    wr(8'h08, 32'h0000_0003); rd(8'h08, 32'h0000_0003);
    wr(8'h0C, 32'h0000_0000); wr(8'h14, 32'h0000_0003);
    wr(8'h50, 32'h0032_0002); wr(8'h54, 32'h0032_0000);
    wr(8'h10, 32'h0000_0011); wr(8'h40, 32'h0032_0002);
    wr(8'h20, 32'h0000_0101); wr(8'h80, 32'h0032_0002);
    $display("test registers done");
    fire(5'h02, 1); chk({running_q, requested_q, shot_running_q}, 10'h221);
    drop; reclose; wait_mode <= 1;
    fire(5'h02, 1); chk({running_q, requested_q, shot_running_q}, 10'h222);
    drop; reclose; wait_mode <= 0;
    fire(5'h02, 1); chk({running_q, requested_q, final_trip_q}, 7'h01);
    drop; await(0, 1);
    fire(5'h02, 0); chk(running_q, 0);
    drop; ext_reset <= 1;
    @(posedge clk_sys); ext_reset <= 0;
    await(0, 0);
    $display("test shots done");
    fire(5'h02, 0); drop; reclose;
    critical_req <= 1;
    @(posedge clk_sys); critical_req <= 0;
    await(0, 1); chk(running_q, 0);
    wr(8'h00, 32'h0000_0005); await(0, 0);
    fire(5'h03, 0); chk(requested_q, 5'h01);
    await(1, 1); drop; reclose;
    // let the shot reclaim run out, so the interlock below starts from idle
    repeat (220) @(posedge clk_sys);
    chk(running_q, 0);
    fire(5'h10, 1); await(2, 1);
    drop; await(0, 1);
    $display("test abort done");
    wr(8'h00, 32'h0000_0005); await(0, 0);
    wr(8'h14, 32'h0000_0203); fire(5'h02, 0); drop; reclose;
    fire(5'h02, 1); await(2, 1); drop; await(0, 1);
    wr(8'h00, 32'h0000_0005); await(0, 0);
    fail_mode <= 1;
    fire(5'h02, 0); drop; await(0, 1); chk(obj_close_cmd_q, 0);
    rd(8'h04, 32'h0000_110A);
    $display("test failure done");
    test_done;
  end
endmodule // auto_reclose_sequencer_test
